// ---- include/icl_pkg.sv ----
// constants, types and helpers shared by the input current limit register bank
package icl_pkg;

  // command codes
  localparam logic [7:0] CMD_APPLIED = 8'h22;
  localparam logic [7:0] CMD_HOST = 8'h3f;

  // field layout
  localparam int CODE_W = 7;
  localparam int FIELD_LSB = 8;
  localparam int FIELD_MSB = 14;
  localparam int RSVD_BIT = 15;
  localparam int RSVD_HI_IN_BYTE = 7;

  // reset and restore words
  localparam logic [15:0] HOST_RESET_WORD = 16'h4000;
  localparam logic [15:0] HOST_RESTORE_WORD = 16'h4100;
  localparam logic [6:0] APPLIED_RESET_CODE = 7'h00;

  // scaling in milliamps
  localparam logic [12:0] STEP_MA = 13'h0032;
  localparam logic [12:0] OFFSET_MA = 13'h0032;

  // serial framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_CMD = 3'b011,
    ST_CMD_ACK = 3'b100,
    ST_WDATA = 3'b101,
    ST_WDATA_ACK = 3'b110,
    ST_RDATA = 3'b111
  } icl_state_e;

  // code to milliamps including the offset
  function automatic logic [12:0] code_to_ma(input logic [6:0] code);
    code_to_ma = ({6'h00, code} * STEP_MA) + OFFSET_MA;
  endfunction

  // code placed into a full register word, reserved bits zero
  function automatic logic [15:0] code_to_word(input logic [6:0] code);
    code_to_word = {1'b0, code, 8'h00};
  endfunction

endpackage

// ---- verilog/icl_line_monitor.sv ----
// bus line sampler producing clock edges, start and stop events
`timescale 1ns/100ps
`default_nettype none
module icl_line_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  // events
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det,
  output logic sda_level
);

  logic scl_q_r;
  logic scl_p_r;
  logic sda_q_r;
  logic sda_p_r;

  // idle bus is high, so reset to high to avoid a false start
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_q_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_q_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_q_r <= scl_in;
      scl_p_r <= scl_q_r;
      sda_q_r <= sda_in;
      sda_p_r <= sda_q_r;
    end
  end

  // sda moving while scl stays high marks start or stop
  assign scl_rise = scl_q_r & ~scl_p_r;
  assign scl_fall = ~scl_q_r & scl_p_r;
  assign start_det = scl_q_r & scl_p_r & sda_p_r & ~sda_q_r;
  assign stop_det = scl_q_r & scl_p_r & ~sda_p_r & sda_q_r;
  assign sda_level = sda_q_r;

endmodule
`default_nettype wire

// ---- verilog/icl_applied_limit.sv ----
// selects the limit regulation uses, from the host or from the optimizer
`timescale 1ns/100ps
`default_nettype none
module icl_applied_limit (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // sources
  input wire logic [6:0] host_code,
  input wire logic optimizer_active,
  input wire logic [6:0] optimizer_code,
  // result
  output logic [6:0] applied_code,
  output logic [12:0] applied_ma
);

  logic [6:0] applied_code_r;
  logic [6:0] applied_code_nxt;
  logic [12:0] applied_ma_r;

  // optimizer value wins while it runs, else mirror the host code
  assign applied_code_nxt = optimizer_active ? optimizer_code : host_code;

  always_ff @(posedge clk) begin
    if (reset) begin
      applied_code_r <= icl_pkg::APPLIED_RESET_CODE;
      applied_ma_r <= icl_pkg::code_to_ma(icl_pkg::APPLIED_RESET_CODE);
    end else begin
      applied_code_r <= applied_code_nxt;
      applied_ma_r <= icl_pkg::code_to_ma(applied_code_nxt);
    end
  end

  assign applied_code = applied_code_r;
  assign applied_ma = applied_ma_r;

endmodule
`default_nettype wire

// ---- verilog/icl_regs.sv ----
// serial word slave holding the host and applied input current limit registers
`timescale 1ns/100ps
`default_nettype none
module icl_regs #(
  // bus address, value arbitrary
  parameter logic [6:0] SLAVE_ADDR = 7'h2a
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // serial bus, sda open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // power path status
  input wire logic source_present,
  input wire logic optimizer_active,
  input wire logic [6:0] optimizer_code,
  // limits toward regulation
  output logic [6:0] host_limit_code,
  output logic [12:0] host_limit_ma,
  output logic [6:0] applied_limit_code,
  output logic [12:0] applied_limit_ma,
  // write rejected because of reserved bit
  output logic invalid_write
);

  // line events from the sampler
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_level;

  icl_line_monitor u_line (
    .clk(clk),
    .reset(reset),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det),
    .sda_level(sda_level)
  );

  // sequencer state, counters and their next values
  icl_pkg::icl_state_e state_r;
  icl_pkg::icl_state_e state_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic oe_r;
  logic oe_nxt;
  logic rw_r;
  logic rw_nxt;
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic [7:0] low_r;
  logic [7:0] low_nxt;
  logic [1:0] idx_r;
  logic [1:0] idx_nxt;
  logic [15:0] rword_r;
  logic [15:0] rword_nxt;
  logic macked_r;
  logic macked_nxt;
  logic in_rack_r;
  logic in_rack_nxt;
  // write strobe, stored limit and status
  logic wr_stb;
  logic [6:0] host_code_r;
  logic [12:0] host_ma_r;
  logic invalid_r;
  logic src_prev_r;
  logic [6:0] applied_code;

  // decode
  wire byte_done = (bit_cnt_r == icl_pkg::BITS_PER_BYTE);
  wire addr_hit = (shift_r[7:1] == SLAVE_ADDR);
  wire [15:0] wr_word = {shift_r, low_r};
  // register selection and the reserved bit check
  wire hit_host = (cmd_r == icl_pkg::CMD_HOST);
  wire hit_applied = (cmd_r == icl_pkg::CMD_APPLIED);
  wire wr_reserved = wr_word[icl_pkg::RSVD_BIT];
  wire host_wr_ok = wr_stb & hit_host & ~wr_reserved;
  wire host_wr_bad = wr_stb & hit_host & wr_reserved;
  // a falling source level loads the restore code, not the reset code
  wire source_removed = src_prev_r & ~source_present;
  wire [6:0] restore_code = icl_pkg::HOST_RESTORE_WORD[icl_pkg::FIELD_MSB:icl_pkg::FIELD_LSB];
  wire [6:0] reset_code = icl_pkg::HOST_RESET_WORD[icl_pkg::FIELD_MSB:icl_pkg::FIELD_LSB];

  // read word is sampled whole at the read address, so both bytes stay coherent;
  // unmapped commands read as zero
  wire [15:0] read_mux = hit_host ? icl_pkg::code_to_word(host_code_r) :
                         hit_applied ? icl_pkg::code_to_word(applied_code) :
                         16'h0000;
  // second read byte is the high half; any later byte reads zero
  wire [7:0] next_rbyte = (idx_r == 2'h0) ? rword_r[15:8] : 8'h00;

  // slave sequencer; low byte travels first, high byte second
  always_comb begin
    // hold everything unless an event moves it
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    oe_nxt = oe_r;
    rw_nxt = rw_r;
    cmd_nxt = cmd_r;
    low_nxt = low_r;
    idx_nxt = idx_r;
    rword_nxt = rword_r;
    macked_nxt = macked_r;
    in_rack_nxt = in_rack_r;
    wr_stb = 1'b0;
    // stop and start outrank whatever byte is in flight
    if (stop_det) begin
      state_nxt = icl_pkg::ST_IDLE;
      oe_nxt = 1'b0;
      in_rack_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt = icl_pkg::ST_ADDR;
      bit_cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
      in_rack_nxt = 1'b0;
    end else begin
      case (state_r)
        icl_pkg::ST_IDLE: begin
          oe_nxt = 1'b0;
        end
        icl_pkg::ST_ADDR, icl_pkg::ST_CMD, icl_pkg::ST_WDATA: begin
          // shift on the rising clock; act on the falling clock after eight bits
          if (scl_rise && !byte_done) begin
            shift_nxt = {shift_r[6:0], sda_level};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall && byte_done) begin
            oe_nxt = 1'b1;
            if (state_r == icl_pkg::ST_ADDR) begin
              if (addr_hit) begin
                rw_nxt = shift_r[0];
                rword_nxt = read_mux;
                state_nxt = icl_pkg::ST_ADDR_ACK;
              end else begin
                oe_nxt = 1'b0;
                state_nxt = icl_pkg::ST_IDLE;
              end
            end else if (state_r == icl_pkg::ST_CMD) begin
              cmd_nxt = shift_r;
              idx_nxt = 2'h0;
              state_nxt = icl_pkg::ST_CMD_ACK;
            end else begin
              // bytes past the second are acked and dropped
              if (idx_r == 2'h0) begin
                low_nxt = shift_r;
              end else if (idx_r == 2'h1) begin
                wr_stb = 1'b1;
              end
              if (idx_r != 2'h2) begin
                idx_nxt = idx_r + 2'h1;
              end
              state_nxt = icl_pkg::ST_WDATA_ACK;
            end
          end
        end
        icl_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_nxt = 4'h0;
            // the first read bit goes out as soon as the ack slot ends
            if (rw_r) begin
              shift_nxt = rword_r[7:0];
              oe_nxt = ~rword_r[7];
              idx_nxt = 2'h0;
              in_rack_nxt = 1'b0;
              state_nxt = icl_pkg::ST_RDATA;
            end else begin
              oe_nxt = 1'b0;
              state_nxt = icl_pkg::ST_CMD;
            end
          end
        end
        icl_pkg::ST_CMD_ACK, icl_pkg::ST_WDATA_ACK: begin
          // release the ack, then collect data bytes
          if (scl_fall) begin
            oe_nxt = 1'b0;
            bit_cnt_nxt = 4'h0;
            state_nxt = icl_pkg::ST_WDATA;
          end
        end
        icl_pkg::ST_RDATA: begin
          // slave transmit: a new bit leaves on each falling clock, except the one after the eighth bit, which frees the line
          if (!in_rack_r) begin
            if (scl_rise) begin
              bit_cnt_nxt = bit_cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (byte_done) begin
                oe_nxt = 1'b0;
                in_rack_nxt = 1'b1;
              end else begin
                shift_nxt = {shift_r[6:0], 1'b0};
                oe_nxt = ~shift_r[6];
              end
            end
          end else begin
            // master acknowledge slot: low means send another byte
            if (scl_rise) begin
              macked_nxt = ~sda_level;
            end else if (scl_fall) begin
              in_rack_nxt = 1'b0;
              bit_cnt_nxt = 4'h0;
              if (macked_r) begin
                shift_nxt = next_rbyte;
                oe_nxt = ~next_rbyte[7];
                if (idx_r != 2'h2) begin
                  idx_nxt = idx_r + 2'h1;
                end
              end else begin
                state_nxt = icl_pkg::ST_IDLE;
              end
            end
          end
        end
        default: begin
          state_nxt = icl_pkg::ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= icl_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      oe_r <= 1'b0;
      rw_r <= 1'b0;
      cmd_r <= 8'h00;
      low_r <= 8'h00;
      idx_r <= 2'h0;
      rword_r <= 16'h0000;
      macked_r <= 1'b0;
      in_rack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      oe_r <= oe_nxt;
      rw_r <= rw_nxt;
      cmd_r <= cmd_nxt;
      low_r <= low_nxt;
      idx_r <= idx_nxt;
      rword_r <= rword_nxt;
      macked_r <= macked_nxt;
      in_rack_r <= in_rack_nxt;
    end
  end

  // host limit storage; only the code is kept, so low byte writes vanish.
  // source removal outranks a write landing in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      host_code_r <= reset_code;
      host_ma_r <= icl_pkg::code_to_ma(reset_code);
      src_prev_r <= 1'b0;
      invalid_r <= 1'b0;
    end else begin
      src_prev_r <= source_present;
      invalid_r <= host_wr_bad;
      if (source_removed) begin
        host_code_r <= restore_code;
        host_ma_r <= icl_pkg::code_to_ma(restore_code);
      end else if (host_wr_ok) begin
        host_code_r <= wr_word[icl_pkg::FIELD_MSB:icl_pkg::FIELD_LSB];
        host_ma_r <= icl_pkg::code_to_ma(wr_word[icl_pkg::FIELD_MSB:icl_pkg::FIELD_LSB]);
      end
    end
  end

  // writes to the applied register fall through: it has no write path
  icl_applied_limit u_applied (
    .clk(clk),
    .reset(reset),
    .host_code(host_code_r),
    .optimizer_active(optimizer_active),
    .optimizer_code(optimizer_code),
    .applied_code(applied_code),
    .applied_ma(applied_limit_ma)
  );

  // outputs
  // open drain: the pin is only ever pulled low, sda_oe says when
  assign sda_out = 1'b0;
  assign sda_oe = oe_r;
  assign host_limit_code = host_code_r;
  assign host_limit_ma = host_ma_r;
  assign applied_limit_code = applied_code;
  assign invalid_write = invalid_r;

endmodule
`default_nettype wire

// ---- verification/icl_regs_checker.sv ----
// port checks for the input current limit register bank
`timescale 1ns/100ps
`default_nettype none
module icl_regs_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // power path status
  input wire logic source_present,
  input wire logic optimizer_active,
  input wire logic [6:0] optimizer_code,
  // limits
  input wire logic [6:0] host_limit_code,
  input wire logic [12:0] host_limit_ma,
  input wire logic [6:0] applied_limit_code,
  input wire logic [12:0] applied_limit_ma,
  input wire logic invalid_write
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // stop: data released while the bus clock is high
  sequence s_stop;
    scl_in && $rose(sda_in);
  endsequence
  // refused write flag lasts one cycle
  sequence s_pulse;
    invalid_write ##1 !invalid_write;
  endsequence

  property p_reset_vals;
    $fell(reset) |-> host_limit_code == 7'h40 && applied_limit_code == 7'h00 && !invalid_write;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("limits wrong after reset");
  property p_host_ma;
    host_limit_ma == 13'(host_limit_code) * 13'h0032 + 13'h0032;
  endproperty
  a_host_ma: assert property (p_host_ma)
    else $error("host milliamps wrong");
  property p_applied_ma;
    applied_limit_ma == 13'(applied_limit_code) * 13'h0032 + 13'h0032;
  endproperty
  a_applied_ma: assert property (p_applied_ma)
    else $error("applied milliamps wrong");
  property p_follow_host;
    !$past(reset) && !$past(optimizer_active) |-> applied_limit_code == $past(host_limit_code);
  endproperty
  a_follow_host: assert property (p_follow_host)
    else $error("applied code does not follow host");
  property p_follow_opt;
    !$past(reset) && $past(optimizer_active) |-> applied_limit_code == $past(optimizer_code);
  endproperty
  a_follow_opt: assert property (p_follow_opt)
    else $error("applied code does not follow optimizer");
  property p_pulse;
    $rose(invalid_write) |-> s_pulse;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("refused write flag not one cycle");
  property p_inv_keep;
    invalid_write |-> $stable(host_limit_code) ##1 $stable(host_limit_code);
  endproperty
  a_inv_keep: assert property (p_inv_keep)
    else $error("refused write changed host code");
  property p_restore;
    $fell(source_present) |-> ##[1:3] host_limit_code == 7'h41;
  endproperty
  a_restore: assert property (p_restore)
    else $error("host code not restored on source removal");
  property p_oe_stop;
    s_stop |=> !sda_oe [*4];
  endproperty
  a_oe_stop: assert property (p_oe_stop)
    else $error("data driven after stop");
  property p_oe_scl_low;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data changed while bus clock high");
endmodule
bind icl_regs icl_regs_checker icl_regs_checker_i (.clk, .reset, .scl_in, .sda_in, .sda_out,
  .sda_oe, .source_present, .optimizer_active, .optimizer_code, .host_limit_code,
  .host_limit_ma, .applied_limit_code, .applied_limit_ma, .invalid_write);
`default_nettype wire

// ---- verification/icl_host_model.sv ----
// serial bus host issuing word reads and writes
`timescale 1ns/100ps
`default_nettype none
module icl_host_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  // clock
  input wire logic clk,
  // bus lines, data resolved outside
  output logic scl,
  output logic sda_low,
  input wire logic sda,
  // read results
  output logic rd_done,
  output logic [15:0] rd_word
);
  // idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_done = 1'b0;
    rd_word = 16'h0000;
  end
  // five cycles per phase, more than the two-flop sampling needs
  task automatic half();
    repeat (5) @(posedge clk);
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_low <= ~b;
    half();
    scl <= 1'b1;
    half();
    r = sda;
    scl <= 1'b0;
    half();
  endtask
  // serves as start and repeated start
  task automatic start();
    sda_low <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b1;
    half();
    scl <= 1'b0;
    half();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_low <= 1'b0;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(~mack, r);
  endtask
  // top bit is sent clear unless a refusal is wanted
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] w);
    write_word_to(ADDR, cmd, w);
  endtask
  // same word write toward any bus address, so a foreign one can be tried
  task automatic write_word_to(input logic [6:0] a, input logic [7:0] cmd, input logic [15:0] w);
    logic [7:0] rx;
    start();
    xfer({a, 1'b0}, 1'b0, rx);
    xfer(cmd, 1'b0, rx);
    xfer(w[7:0], 1'b0, rx);
    xfer(w[15:8], 1'b0, rx);
    stop();
  endtask
  task automatic read_word(input logic [7:0] cmd);
    logic [7:0] lo, hi;
    start();
    xfer({ADDR, 1'b0}, 1'b0, lo);
    xfer(cmd, 1'b0, lo);
    start();
    xfer({ADDR, 1'b1}, 1'b0, lo);
    xfer(8'hff, 1'b1, lo);
    xfer(8'hff, 1'b0, hi);
    stop();
    rd_word <= {hi, lo};
    rd_done <= 1'b1;
    @(posedge clk);
    rd_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verification/icl_regs_tb.sv ----
// self-checking bench for the input current limit register bank
`timescale 1ns/100ps
`default_nettype none
module icl_regs_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic source_present = 1'b1;
  logic optimizer_active = 1'b0;
  logic [6:0] optimizer_code = 7'h00;
  logic scl, sda_low, sda, sda_out, sda_oe, rd_done, invalid_write;
  logic [15:0] rd_word;
  logic [6:0] host_limit_code, applied_limit_code, code, oc;
  logic [12:0] host_limit_ma, applied_limit_ma;
  logic [7:0] lo;
  logic [15:0] exp_q[$];
  int mismatches = 0;
  int num_checks = 0;
  int inv_seen = 0;

  always #4 clk = ~clk;
  // pull-up: either party pulls the data line low
  assign sda = ~(sda_low | sda_oe);

  icl_regs icl_regs_i (.clk, .reset, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .source_present, .optimizer_active, .optimizer_code, .host_limit_code, .host_limit_ma,
    .applied_limit_code, .applied_limit_ma, .invalid_write);
  icl_host_model icl_host_model_i (.clk, .scl, .sda_low, .sda, .rd_done, .rd_word);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] ma(input logic [6:0] c);
    return {3'h0, 13'(c) * 13'h0032 + 13'h0032};
  endfunction
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    exp_q.push_back(exp);
    icl_host_model_i.read_word(cmd);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // each finished read is matched with the oldest expected word
  always @(posedge clk) begin
    if (rd_done === 1'b1) check(rd_word, exp_q.pop_front());
  end

  // count refusal pulses so the bench sees the flag, not only the checker
  always @(posedge clk) begin
    if (invalid_write === 1'b1) inv_seen++;
  end

  // main sequence
  initial begin
    void'($urandom(32'hd007));
    repeat (6) @(posedge clk);
    check({9'h000, applied_limit_code}, 16'h0000);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h3f, 16'h4000);
    rd(8'h22, 16'h4000);
    rd(8'h3e, 16'h0000);
    // boundary codes then random ones, junk in the low byte
    for (int i = 0; i < 4; i++) begin
      code = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'($urandom);
      lo = 8'($urandom);
      icl_host_model_i.write_word(8'h3f, {1'b0, code, lo});
      rd(8'h3f, {1'b0, code, 8'h00});
      rd(8'h22, {1'b0, code, 8'h00});
      check({3'h0, host_limit_ma}, ma(code));
    end
    // reserved top bit set: the whole word must be dropped
    icl_host_model_i.write_word(8'h3f, {1'b1, ~code, 8'h00});
    // a foreign bus address must leave the register alone as well
    icl_host_model_i.write_word_to(7'h55, 8'h3f, {1'b0, ~code, 8'h00});
    rd(8'h3f, {1'b0, code, 8'h00});
    check(16'(inv_seen), 16'h0001);
    oc = 7'($urandom);
    optimizer_code <= oc;
    optimizer_active <= 1'b1;
    icl_host_model_i.write_word(8'h22, 16'h7f00);
    rd(8'h22, {1'b0, oc, 8'h00});
    rd(8'h3f, {1'b0, code, 8'h00});
    check({3'h0, applied_limit_ma}, ma(oc));
    optimizer_active <= 1'b0;
    source_present <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h3f, 16'h4100);
    rd(8'h22, 16'h4100);
    check({15'h0000, sda_out}, 16'h0000);
    repeat (4) @(posedge clk);
    give_verdict();
  end

  // the run needs about 15700 cycles; cut a hang well beyond that
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
